// [rtl/boundary_scan_tap.sv]
`timescale 1ns/1ps
// Functional notes
// - ir codes 0..10: bypass, preload, sample, id, user, clamp, hiz, extest...
// - four pins: tck, tms, tdi in; tdo out; chains devices in one path
// - test logic runs on tck alone and holds all state when tck stops; here the register access handshake also runs on ref_clk
// - tms sampled on rising tck picks the next controller state
// - five cycles of tms high reach test-logic-reset from any state
// - test-logic-reset loads the identification instruction
// - tdi sampled on rising tck into ir or selected data register
// - tdo changes on falling tck, from chain chosen by state and instruction
// - tdo not driven outside shift states
// - bypass passes tdi to tdo through one bit, device undisturbed
// - data register length follows the instruction: 24, 32, 1, 8, 15
// - cells 23..0: odd cells enable even cell; cell 7 if2 out, 6 if3 in
// - self-monitoring bidir cells, input-only cell, control cells
// - id word: version, part, maker code, fixed one
// - user code: three product bytes then version, from memory
// - instruction 8 one bit; 1 at update disables host, enables access
// - instruction 9 captures data at address; update takes new address
// - instruction 10 writes data at address when capture-dr is reached
module boundary_scan_tap #(
  parameter logic [3:0] ID_VERSION = 4'h2, // arbitrary
  parameter logic [15:0] ID_PART = 16'h5a5a, // arbitrary
  parameter logic [10:0] ID_MANUF = 11'h07e // arbitrary
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire tap_pkg::pad_drive_s core_drive,
  input wire logic [11:0] pad_in,
  output tap_pkg::pad_drive_s pad_drive,
  input wire logic [31:0] user_code,
  output logic host_if_disable,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic rst_meta, tap_rst;
  logic [11:0] pad_meta, pad_sync;
  logic [31:0] ucode_meta, ucode_sync;
  logic ack_s1, ack_s2;
  tap_pkg::tap_state_e state;
  logic tlr, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir;
  logic [3:0] ir, next_ir, ir_shift, next_ir_shift, eff;
  logic [31:0] dr_shift, next_dr_shift;
  logic [23:0] bsr, next_bsr;
  logic iface_off, next_iface_off;
  logic [6:0] cur_addr, next_cur_addr;
  logic rd_tgl, next_rd_tgl, wr_tgl, next_wr_tgl, ack_seen, next_ack_seen;
  tap_pkg::reg_req_s wr_req, next_wr_req;
  logic [7:0] rd_data, next_rd_data;
  logic next_tdo, next_tdo_oe;
  logic ack_tgl, next_ack_tgl, rd_pend, next_rd_pend;
  logic [7:0] rd_hold, next_rd_hold;
  tap_pkg::pad_drive_s drive_meta, drive_sync;

  function automatic logic [3:0] eff_instr(input logic [3:0] i,
                                           input logic en);
    if (i == tap_pkg::INS_CLAMP || i == tap_pkg::INS_HIGHZ)
      return tap_pkg::INS_BYPASS;
    if (i == tap_pkg::INS_REGRD || i == tap_pkg::INS_REGWR)
      return en ? i : tap_pkg::INS_BYPASS;
    if (i > tap_pkg::INS_REGWR)
      return tap_pkg::INS_BYPASS;
    return i;
  endfunction

  function automatic logic [5:0] dr_len(input logic [3:0] i);
    unique case (i)
      tap_pkg::INS_PRELOAD, tap_pkg::INS_SAMPLE,
      tap_pkg::INS_EXTEST: return tap_pkg::LEN_BSR;
      tap_pkg::INS_IDCODE, tap_pkg::INS_USERCODE: return tap_pkg::LEN_ID;
      tap_pkg::INS_REGRD: return tap_pkg::LEN_RD;
      tap_pkg::INS_REGWR: return tap_pkg::LEN_WR;
      default: return tap_pkg::LEN_BYPASS;
    endcase
  endfunction

  // data cells watch the pad itself, so extest also reads back the drive
  function automatic logic [23:0] capture_cells(input logic [11:0] pin,
                                                tap_pkg::pad_drive_s c);
    logic [23:0] v;
    v = tap_pkg::BSR_RST;
    for (int k = 0; k < tap_pkg::PIN_N; k++) begin
      v[2*k] = pin[k];
      v[2*k+1] = c.oe[k];
    end
    v[tap_pkg::IF2_OUT_CELL] = c.o[tap_pkg::IF2_PIN];
    return v;
  endfunction

  // tck-side synchronisers; reset and straps settle within two tck
  always_ff @(posedge tck) begin
    rst_meta <= ~resetn;
    tap_rst <= rst_meta;
    pad_meta <= pad_in;
    pad_sync <= pad_meta;
    ucode_meta <= user_code;
    ucode_sync <= ucode_meta;
    drive_meta <= core_drive;
    drive_sync <= drive_meta;
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
  end

  tap_fsm u_fsm (
    .tck(tck),
    .tap_rst(tap_rst),
    .tms(tms),
    .state(state)
  );

  assign tlr = state == tap_pkg::TLR;
  assign cap_dr = state == tap_pkg::CAP_DR;
  assign sh_dr = state == tap_pkg::SH_DR;
  assign upd_dr = state == tap_pkg::UPD_DR;
  assign cap_ir = state == tap_pkg::CAP_IR;
  assign sh_ir = state == tap_pkg::SH_IR;
  assign upd_ir = state == tap_pkg::UPD_IR;
  assign eff = eff_instr(ir, iface_off);

  always_comb begin
    next_ir = ir;
    next_ir_shift = ir_shift;
    next_dr_shift = dr_shift;
    next_bsr = bsr;
    next_iface_off = iface_off;
    next_cur_addr = cur_addr;
    next_rd_tgl = rd_tgl;
    next_wr_tgl = wr_tgl;
    next_wr_req = wr_req;
    next_ack_seen = ack_s2;
    next_rd_data = (ack_s2 != ack_seen) ? rd_hold : rd_data;
    if (tlr) begin
      next_ir = tap_pkg::INS_IDCODE;
      next_iface_off = 1'b0;
    end else if (cap_ir) begin
      next_ir_shift = tap_pkg::IR_CAPTURE;
    end else if (sh_ir) begin
      next_ir_shift = {tdi, ir_shift[3:1]};
    end else if (upd_ir) begin
      next_ir = ir_shift;
    end else if (cap_dr) begin
      unique case (eff)
        tap_pkg::INS_PRELOAD, tap_pkg::INS_SAMPLE, tap_pkg::INS_EXTEST:
          next_dr_shift = {8'h00, capture_cells(pad_sync, drive_sync)};
        tap_pkg::INS_IDCODE:
          next_dr_shift = {ID_VERSION, ID_PART, ID_MANUF, 1'b1};
        tap_pkg::INS_USERCODE: next_dr_shift = ucode_sync;
        tap_pkg::INS_IFACE: next_dr_shift = {31'h0000_0000, iface_off};
        tap_pkg::INS_REGRD: next_dr_shift = {24'h00_0000, rd_data};
        tap_pkg::INS_REGWR: begin
          next_wr_req.addr = dr_shift[6:0];
          next_wr_req.data = dr_shift[14:7];
          next_wr_tgl = ~wr_tgl;
        end
        default: next_dr_shift = 32'h0000_0000;
      endcase
    end else if (sh_dr) begin
      for (int b = 0; b < 32; b++) begin
        if (b == 32'(dr_len(eff)) - 1)
          next_dr_shift[b] = tdi;
        else if (b < 32'(dr_len(eff)) - 1)
          next_dr_shift[b] = dr_shift[b+1];
        else
          next_dr_shift[b] = 1'b0;
      end
    end else if (upd_dr) begin
      unique case (eff)
        tap_pkg::INS_PRELOAD, tap_pkg::INS_EXTEST:
          next_bsr = dr_shift[23:0];
        tap_pkg::INS_IFACE: begin
          next_iface_off = dr_shift[0];
          next_rd_tgl = ~rd_tgl;
        end
        tap_pkg::INS_REGRD: begin
          next_cur_addr = dr_shift[6:0];
          next_rd_tgl = ~rd_tgl;
        end
        default: next_bsr = bsr;
      endcase
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      ir <= tap_pkg::INS_IDCODE;
      ir_shift <= tap_pkg::IR_CAPTURE;
      dr_shift <= 32'h0000_0000;
      bsr <= tap_pkg::BSR_RST;
      iface_off <= 1'b0;
      cur_addr <= tap_pkg::ADDR_RST;
      rd_tgl <= 1'b0;
      wr_tgl <= 1'b0;
      wr_req <= '0;
      ack_seen <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      ir <= next_ir;
      ir_shift <= next_ir_shift;
      dr_shift <= next_dr_shift;
      bsr <= next_bsr;
      iface_off <= next_iface_off;
      cur_addr <= next_cur_addr;
      rd_tgl <= next_rd_tgl;
      wr_tgl <= next_wr_tgl;
      wr_req <= next_wr_req;
      ack_seen <= next_ack_seen;
      rd_data <= next_rd_data;
    end
  end

  // falling edge output so the next device in the chain sees a stable bit
  always_comb begin
    next_tdo = tdo;
    next_tdo_oe = 1'b0;
    if (sh_ir) begin
      next_tdo = ir_shift[0];
      next_tdo_oe = 1'b1;
    end else if (sh_dr) begin
      next_tdo = dr_shift[0];
      next_tdo_oe = 1'b1;
    end
  end

  always_ff @(negedge tck) begin
    if (tap_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  // pad steering follows the updated ir only, never the shifting one
  always_comb begin
    pad_drive = core_drive;
    if (ir == tap_pkg::INS_HIGHZ) begin
      pad_drive.oe = 12'h000;
    end else if (ir == tap_pkg::INS_EXTEST || ir == tap_pkg::INS_CLAMP) begin
      for (int k = 0; k < tap_pkg::PIN_N; k++) begin
        pad_drive.o[k] = bsr[2*k];
        pad_drive.oe[k] = bsr[2*k+1];
      end
      pad_drive.o[tap_pkg::IF2_PIN] = bsr[tap_pkg::IF2_OUT_CELL];
      pad_drive.oe[tap_pkg::IF3_PIN] = 1'b0;
    end
  end

  // ref_clk side: toggle handshakes; payload moves on the same edge as its toggle and is stable before the synced toggle is seen
  logic rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3, if_s1, if_s2;
  logic next_reg_wr_en, next_reg_rd_en;
  logic [6:0] next_reg_addr;
  logic [7:0] next_reg_wdata;

  always_ff @(posedge ref_clk) begin
    rd_s1 <= rd_tgl;
    rd_s2 <= rd_s1;
    wr_s1 <= wr_tgl;
    wr_s2 <= wr_s1;
    if_s1 <= iface_off;
    if_s2 <= if_s1;
  end

  assign host_if_disable = if_s2;

  always_comb begin
    next_reg_wr_en = wr_s2 ^ wr_s3;
    next_reg_rd_en = rd_s2 ^ rd_s3;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    if (wr_s2 ^ wr_s3) begin
      next_reg_addr = wr_req.addr;
      next_reg_wdata = wr_req.data;
    end else if (rd_s2 ^ rd_s3) begin
      next_reg_addr = cur_addr;
    end
    next_rd_pend = reg_rd_en;
    next_rd_hold = rd_pend ? reg_rdata : rd_hold;
    next_ack_tgl = rd_pend ? ~ack_tgl : ack_tgl;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_s3 <= 1'b0;
      wr_s3 <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_addr <= tap_pkg::ADDR_RST;
      reg_wdata <= 8'h00;
      rd_pend <= 1'b0;
      rd_hold <= 8'h00;
      ack_tgl <= 1'b0;
    end else begin
      rd_s3 <= rd_s2;
      wr_s3 <= wr_s2;
      reg_wr_en <= next_reg_wr_en;
      reg_rd_en <= next_reg_rd_en;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      rd_pend <= next_rd_pend;
      rd_hold <= next_rd_hold;
      ack_tgl <= next_ack_tgl;
    end
  end

  property p_tlr_id;
    @(posedge tck) disable iff (tap_rst) tlr |=> ir == tap_pkg::INS_IDCODE;
  endproperty
  a_tlr_id: assert property (p_tlr_id)
    else $error("reset state did not select identification");

  property p_tdo_idle;
    @(posedge tck) disable iff (tap_rst)
    !(sh_dr || sh_ir) && !$past(tap_rst) |-> !tdo_oe;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle)
    else $error("tdo driven outside shift");

  property p_bypass;
    @(posedge tck) disable iff (tap_rst)
    sh_dr && eff == tap_pkg::INS_BYPASS |=> dr_shift[0] == $past(tdi);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass bit did not carry tdi");

  property p_id_len;
    @(posedge tck) disable iff (tap_rst)
    sh_dr && eff == tap_pkg::INS_IDCODE |=> dr_shift[31] == $past(tdi);
  endproperty
  a_id_len: assert property (p_id_len)
    else $error("id chain not 32 bits");

  property p_bsr_len;
    @(posedge tck) disable iff (tap_rst)
    sh_dr && eff == tap_pkg::INS_EXTEST
      |=> dr_shift[23] == $past(tdi) && dr_shift[24] == 1'b0;
  endproperty
  a_bsr_len: assert property (p_bsr_len)
    else $error("boundary chain not 24 bits");

  property p_iface;
    @(posedge tck) disable iff (tap_rst)
    upd_dr && eff == tap_pkg::INS_IFACE |=> iface_off == $past(dr_shift[0]);
  endproperty
  a_iface: assert property (p_iface)
    else $error("interface bit not taken at update");

  property p_rd_addr;
    @(posedge tck) disable iff (tap_rst)
    upd_dr && eff == tap_pkg::INS_REGRD
      |=> cur_addr == $past(dr_shift[6:0]) && rd_tgl != $past(rd_tgl);
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("read address not taken at update");

  property p_wr;
    @(posedge tck) disable iff (tap_rst)
    cap_dr && eff == tap_pkg::INS_REGWR
      |=> wr_tgl != $past(wr_tgl) && wr_req.data == $past(dr_shift[14:7]);
  endproperty
  a_wr: assert property (p_wr)
    else $error("write not launched at capture");

  property p_clamp;
    @(posedge tck) disable iff (tap_rst)
    ir == tap_pkg::INS_CLAMP
      |-> pad_drive.o[0] == bsr[0] && pad_drive.oe[0] == bsr[1]
          && eff == tap_pkg::INS_BYPASS;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp not driving from boundary register");

  property p_highz;
    @(posedge tck) disable iff (tap_rst)
    ir == tap_pkg::INS_HIGHZ |-> pad_drive.oe == 12'h000;
  endproperty
  a_highz: assert property (p_highz)
    else $error("pin driver on under high impedance");

  c_id: cover property (@(posedge tck) sh_dr && eff == tap_pkg::INS_IDCODE);
  c_ext: cover property (@(posedge tck) upd_dr && ir == tap_pkg::INS_EXTEST);
  c_wr: cover property (@(posedge ref_clk) reg_wr_en);
  c_rd: cover property (@(posedge ref_clk) rd_pend);

endmodule // boundary_scan_tap

// [rtl/tap_pkg.sv]
package tap_pkg;

  typedef enum logic [3:0] {
    TLR    = 4'h0,
    RTI    = 4'h1,
    SEL_DR = 4'h2,
    CAP_DR = 4'h3,
    SH_DR  = 4'h4,
    EX1_DR = 4'h5,
    PAU_DR = 4'h6,
    EX2_DR = 4'h7,
    UPD_DR = 4'h8,
    SEL_IR = 4'h9,
    CAP_IR = 4'ha,
    SH_IR  = 4'hb,
    EX1_IR = 4'hc,
    PAU_IR = 4'hd,
    EX2_IR = 4'he,
    UPD_IR = 4'hf
  } tap_state_e;

  localparam logic [3:0] INS_BYPASS = 4'h0;
  localparam logic [3:0] INS_PRELOAD = 4'h1;
  localparam logic [3:0] INS_SAMPLE = 4'h2;
  localparam logic [3:0] INS_IDCODE = 4'h3;
  localparam logic [3:0] INS_USERCODE = 4'h4;
  localparam logic [3:0] INS_CLAMP = 4'h5;
  localparam logic [3:0] INS_HIGHZ = 4'h6;
  localparam logic [3:0] INS_EXTEST = 4'h7;
  localparam logic [3:0] INS_IFACE = 4'h8;
  localparam logic [3:0] INS_REGRD = 4'h9;
  localparam logic [3:0] INS_REGWR = 4'ha;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  localparam logic [5:0] LEN_BYPASS = 6'h01;
  localparam logic [5:0] LEN_BSR = 6'h18;
  localparam logic [5:0] LEN_ID = 6'h20;
  localparam logic [5:0] LEN_RD = 6'h08;
  localparam logic [5:0] LEN_WR = 6'h0f;

  localparam int PIN_N = 12;
  localparam int BSR_N = 24;
  localparam int IF3_PIN = 3;
  localparam int IF2_PIN = 4;
  localparam int IF2_OUT_CELL = 7;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int TMS_RESET_CYCLES = 5;

  localparam logic [23:0] BSR_RST = 24'h00_0000;
  localparam logic [6:0] ADDR_RST = 7'h00;

  typedef struct packed {
    logic [PIN_N-1:0] o;
    logic [PIN_N-1:0] oe;
  } pad_drive_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_req_s;

endpackage

// [rtl/tap_fsm.sv]
`timescale 1ns/1ps
module tap_fsm (
  input wire logic tck,
  input wire logic tap_rst,
  input wire logic tms,
  output tap_pkg::tap_state_e state
);
  tap_pkg::tap_state_e next_state;
  logic [2:0] ones;
  logic [2:0] next_ones;

  always_comb begin
    next_state = state;
    unique case (state)
      tap_pkg::TLR:    next_state = tms ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI:    next_state = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: next_state = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: next_state = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR:  next_state = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: next_state = tms ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
      tap_pkg::PAU_DR: next_state = tms ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
      tap_pkg::EX2_DR: next_state = tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: next_state = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: next_state = tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: next_state = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR:  next_state = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: next_state = tms ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
      tap_pkg::PAU_IR: next_state = tms ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
      tap_pkg::EX2_IR: next_state = tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: next_state = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
    endcase
    next_ones = tms ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
  end

  // tms sampled only on rising tck; a stopped tck holds the state
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      state <= tap_pkg::TLR;
      ones <= 3'h0;
    end else begin
      state <= next_state;
      ones <= next_ones;
    end
  end

  property p_five_ones;
    @(posedge tck) disable iff (tap_rst)
    (ones >= 3'(tap_pkg::TMS_RESET_CYCLES)) |-> state == tap_pkg::TLR;
  endproperty
  a_five_ones: assert property (p_five_ones)
    else $error("tms high five cycles without reset state");

  property p_shift_exit;
    @(posedge tck) disable iff (tap_rst)
    (state == tap_pkg::SH_DR && tms) |=> state == tap_pkg::EX1_DR;
  endproperty
  a_shift_exit: assert property (p_shift_exit)
    else $error("shift-dr with tms high did not exit");

  property p_tlr_leave;
    @(posedge tck) disable iff (tap_rst)
    (state == tap_pkg::TLR && !tms) ##1 !tms |=> state == tap_pkg::RTI;
  endproperty
  a_tlr_leave: assert property (p_tlr_leave)
    else $error("reset state did not move to idle");

endmodule // tap_fsm

// [testbench/jtag_tester.sv]
`timescale 1ns/1ps
module jtag_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic [31:0] res_word,
  output logic [1:0] res_oe,
  output logic res_vld
);
  // idle levels follow the pin pull-ups
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    res_word = '0;
    res_oe = '0;
    res_vld = 1'b0;
  end

  // free-running test clock, 12 ns
  always #6 tck = ~tck;

  // tester only moves tms and tdi on the falling edge
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge tck);
    tms = m;
    tdi = d;
    @(posedge tck);
    q = tdo;
  endtask

  task automatic idle(input int n);
    logic q;
    repeat (n) step(1'b0, 1'b1, q);
  endtask

  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input logic chk);
    logic q;
    logic on;
    logic [31:0] w;
    w = '0;
    on = 1'b1;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(logic'(i == n - 1), din[i], q);
      w[i] = q;
      on = on & tdo_oe;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    if (chk) begin
      res_word = w;
      res_oe = {on, tdo_oe};
      res_vld = 1'b1;
      #1 res_vld = 1'b0;
    end
  endtask
endmodule // jtag_tester

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] VER = 4'h3; // arbitrary
  localparam logic [15:0] PART = 16'h1234; // arbitrary
  localparam logic [10:0] MANUF = 11'h055; // arbitrary
  logic ref_clk, resetn, tck, tms, tdi, tdo, tdo_oe;
  logic host_if_disable, reg_wr_en, reg_rd_en, rd_q, res_vld;
  tap_pkg::pad_drive_s core_drive;
  tap_pkg::pad_drive_s pad_drive;
  tap_pkg::pad_drive_s x;
  logic [11:0] pad_in;
  logic [31:0] user_code, res_word, p;
  logic [23:0] e;
  logic [6:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] res_oe;
  logic q;
  logic [8:0] seq;
  logic [33:0] scan_q[$];
  logic [14:0] wr_q[$];
  int errors, cmp_count, cycles, seed;

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [7:0] rd_val(input logic [6:0] x);
    return {1'b1, x} ^ 8'h5a;
  endfunction

  // data is only right in the cycle after the strobe
  always @(posedge ref_clk) rd_q <= reg_rd_en;
  assign reg_rdata = rd_q ? rd_val(reg_addr) : ~rd_val(reg_addr);

  boundary_scan_tap #(.ID_VERSION(VER), .ID_PART(PART),
                      .ID_MANUF(MANUF)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .core_drive(core_drive), .pad_in(pad_in),
    .pad_drive(pad_drive), .user_code(user_code),
    .host_if_disable(host_if_disable), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  jtag_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .res_word(res_word), .res_oe(res_oe),
    .res_vld(res_vld));

  task automatic check_word(input string what, input logic [33:0] ex,
                            input logic [33:0] got);
    cmp_count++;
    if (got !== ex) begin
      errors++;
      $display("Error %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic check_bit(input string what, input logic ex,
                           input logic got);
    cmp_count++;
    if (got !== ex) begin
      errors++;
      $display("Error %s expected %b seen %b", what, ex, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge res_vld) begin
    check_word("scan out", scan_q.pop_front(), {res_oe, res_word});
  end

  always @(posedge ref_clk) begin
    if (reg_wr_en === 1'b1 && wr_q.size() > 0) begin
      check_word("reg write", 34'(wr_q.pop_front()),
                 {19'h0, reg_addr, reg_wdata});
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    seed = 96;
    pad_in = 12'($random(seed));
    core_drive = 24'($random(seed));
    user_code = $random(seed);
    // tck side needs three of its own edges inside reset
    repeat (4) @(negedge tck);
    @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge tck);
    i_tester.idle(2);
    scan_q.push_back({2'b10, VER, PART, MANUF, 1'b1});
    i_tester.scan(1'b0, 32, 32'h0, 1'b1);
    $display("test id done");
    for (int c = 0; c < 11; c++) begin
      scan_q.push_back({2'b10, 32'h0000_0001});
      i_tester.scan(1'b1, 4, 32'(c), 1'b1);
    end
    for (int r = 0; r < 2; r++) begin
      user_code = $random(seed);
      i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_USERCODE), 1'b0);
      scan_q.push_back({2'b10, user_code});
      i_tester.scan(1'b0, 32, $random(seed), 1'b1);
    end
    $display("test codes done");
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_BYPASS), 1'b0);
    p = $random(seed);
    scan_q.push_back({2'b10, 24'h00_0000, p[6:0], 1'b0});
    i_tester.scan(1'b0, 8, p, 1'b1);
    check_word("pad drive", 34'(core_drive), 34'(pad_drive));
    $display("test bypass done");
    // fresh drive and pad levels; both cross into tck before capture
    pad_in = 12'($random(seed));
    core_drive = 24'($random(seed));
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_SAMPLE), 1'b0);
    for (int k = 0; k < tap_pkg::PIN_N; k++) begin
      e[2*k] = pad_in[k];
      e[2*k+1] = core_drive.oe[k];
    end
    e[tap_pkg::IF2_OUT_CELL] = core_drive.o[tap_pkg::IF2_PIN];
    scan_q.push_back({2'b10, 8'h00, e});
    i_tester.scan(1'b0, 24, $random(seed), 1'b1);
    p = $random(seed);
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_PRELOAD), 1'b0);
    i_tester.scan(1'b0, 24, p, 1'b0);
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_EXTEST), 1'b0);
    for (int k = 0; k < tap_pkg::PIN_N; k++) begin
      x.o[k] = p[2*k];
      x.oe[k] = p[2*k+1];
    end
    // if2 output comes from cell 7; if3 is input only
    x.o[tap_pkg::IF2_PIN] = p[tap_pkg::IF2_OUT_CELL];
    x.oe[tap_pkg::IF3_PIN] = 1'b0;
    check_word("extest drive", 34'(x), 34'(pad_drive));
    scan_q.push_back({2'b10, 8'h00, e});
    i_tester.scan(1'b0, 24, p, 1'b1);
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_CLAMP), 1'b0);
    check_word("clamp drive", 34'(x), 34'(pad_drive));
    scan_q.push_back({2'b10, 32'h0000_0002});
    i_tester.scan(1'b0, 2, 32'h0000_0003, 1'b1);
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_HIGHZ), 1'b0);
    check_word("pad enables", 34'h0, 34'(pad_drive.oe));
    $display("test boundary done");
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_IFACE), 1'b0);
    i_tester.scan(1'b0, 1, 32'h1, 1'b0);
    i_tester.idle(4);
    check_bit("host disable", 1'b1, host_if_disable);
    a = 7'($random(seed));
    d = 8'($random(seed));
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_REGWR), 1'b0);
    i_tester.scan(1'b0, 15, {17'h0, d, a}, 1'b0);
    i_tester.idle(4);
    wr_q.push_back({a, d});
    i_tester.scan(1'b0, 15, {17'h0, d, a}, 1'b0);
    i_tester.idle(4);
    check_word("write count", 34'h0, 34'(wr_q.size()));
    i_tester.scan(1'b1, 4, 32'(tap_pkg::INS_REGRD), 1'b0);
    i_tester.idle(4);
    scan_q.push_back({2'b10, 24'h00_0000, rd_val(7'h00)});
    i_tester.scan(1'b0, 8, {24'h0, 1'b0, a}, 1'b1);
    i_tester.idle(4);
    scan_q.push_back({2'b10, 24'h00_0000, rd_val(a)});
    i_tester.scan(1'b0, 8, 32'h0, 1'b1);
    $display("test register access done");
    // into shift-dr, then five highs from mid-shift
    seq = 9'b0_1111_1001;
    for (int i = 0; i < 9; i++) i_tester.step(seq[i], 1'b1, q);
    i_tester.idle(4);
    check_bit("host disable", 1'b0, host_if_disable);
    scan_q.push_back({2'b10, VER, PART, MANUF, 1'b1});
    i_tester.scan(1'b0, 32, 32'h0, 1'b1);
    $display("test mode reset done");
    i_tester.idle(2);
    tally_and_finish();
  end
endmodule // tb_top
